// >>> hdl/pmcs_cfg.svh
`ifndef PMCS_CFG_SVH
`define PMCS_CFG_SVH

// register byte offsets
`define PMCS_OFS_CONFIG 5'h00
`define PMCS_OFS_CALIB 5'h04
`define PMCS_OFS_STATUS 5'h08
`define PMCS_OFS_SHUNT 5'h0c
`define PMCS_OFS_BUS 5'h10
`define PMCS_OFS_CURRENT 5'h14
`define PMCS_OFS_POWER 5'h18

// config field positions
`define PMCS_MODE_LSB 0
`define PMCS_MODE_MSB 2
`define PMCS_AVG_LSB 9
`define PMCS_AVG_MSB 11

// mode bit meanings
`define PMCS_MODE_SHUNT_BIT 0
`define PMCS_MODE_BUS_BIT 1
`define PMCS_MODE_CONT_BIT 2
`define PMCS_MODE_CONT_BOTH 3'h7

// status field positions
`define PMCS_ST_READY_BIT 0
`define PMCS_ST_BUSY_BIT 1
`define PMCS_ST_PD_BIT 2
`define PMCS_ST_RECOVER_BIT 3

// reset values
`define PMCS_RST_MODE 3'h7
`define PMCS_RST_AVG 3'h0
`define PMCS_RST_CALIB 16'h0000

// arithmetic scaling
`define PMCS_CUR_SHIFT 11
`define PMCS_POW_SHIFT 13
`define PMCS_BUS_LSB_UV 1250
`define PMCS_BUS_FULL_SCALE_MV 40960

// timing
`define PMCS_CLK_HZ 50000000
`define PMCS_RECOVER_US 40
`define PMCS_RECOVER_CYC ((`PMCS_CLK_HZ / 1000000) * `PMCS_RECOVER_US)

`endif

// >>> hdl/pmcs_pkg.sv
`include "pmcs_cfg.svh"

package pmcs_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    S_IDLE,
    S_RECOVER,
    S_START,
    S_WAIT
  } pmcs_state_e;

  typedef logic [15:0] pmcs_word_t;
  typedef logic [31:0] pmcs_acc_t;

  // complete state of the sequencer
  typedef struct packed {
    pmcs_state_e state;
    logic [2:0] mode;
    logic [2:0] avg_sel;
    pmcs_word_t calib;
    logic calib_valid;
    logic ready_flag;
    logic restart_pend;
    logic chan;
    logic adc_start;
    logic power_down;
    logic [11:0] rec_cnt;
    logic [10:0] samp_cnt;
    pmcs_acc_t acc_shunt;
    pmcs_acc_t acc_bus;
    pmcs_acc_t acc_cur;
    pmcs_acc_t acc_pow;
    pmcs_word_t last_cur;
    pmcs_word_t res_shunt;
    pmcs_word_t res_bus;
    pmcs_word_t res_cur;
    pmcs_word_t res_pow;
    logic wait_req;
    logic [31:0] rdata;
  } pmcs_state_s;

endpackage

// >>> hdl/pmcs_top.sv
// Function
// - mode 111 loops shunt then bus conversions with no host action.
// - after each shunt conversion, current is shunt scaled by calibration.
// - after each bus conversion, power is last current times new bus.
// - without a programmed calibration, current and power read zero.
// - samples repeat into accumulators until the averaging count is reached.
// - result registers load only when the whole averaging set completes.
// - results hold until the next complete averaged result replaces them.
// - reading results never disturbs a running conversion or average.
// - modes exist that convert only shunt or only bus voltage.
// - writing mode 001, 010 or 011 runs exactly one set, then stops.
// - registers stay readable and writable while powered down.
// - leaving power-down waits 40 us recovery before converting.
// - power-down lasts until an active mode is written.
// - ready flag sets when conversions, averaging and multiply finish.
// - any config write clears ready flag, unless it selects power-down or an averaging set completes in that cycle.
// - reading status clears the ready flag, unless an averaging set completes in that cycle.
// - current and power math runs alongside, adding no conversion time.
// - with averaging above one, per-sample values go to accumulators.
// - all four quantities accumulate when both channels run; averages load at end of set.
// - bus result is 1.25 mV per bit, 40.96 V full scale.
`include "pmcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module pmcs_top #(
  parameter int RECOVER_CYC = `PMCS_RECOVER_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // converter front end
  output logic adc_start,
  output logic adc_channel,
  output logic adc_power_down,
  input wire logic adc_done,
  input wire pmcs_pkg::pmcs_word_t adc_data,
  // status level
  output logic conversion_ready_flag
);
  import pmcs_pkg::*;

  pmcs_state_s st_reg;
  pmcs_state_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // averaging code to shift: 1,4,16,64,128,256,512,1024 samples
  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    logic [3:0] sh;
    sh = 4'h0;
    unique case (sel)
      3'h0: sh = 4'h0;
      3'h1: sh = 4'h2;
      3'h2: sh = 4'h4;
      3'h3: sh = 4'h6;
      3'h4: sh = 4'h7;
      3'h5: sh = 4'h8;
      3'h6: sh = 4'h9;
      3'h7: sh = 4'ha;
    endcase
    return sh;
  endfunction

  // byte-lane merge of a 32-bit write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // first channel of a sample: shunt unless the mode skips it
  function automatic logic first_chan(input logic [2:0] m);
    return ~m[`PMCS_MODE_SHUNT_BIT];
  endfunction

  // a mode with neither channel enabled is power-down
  function automatic logic is_pd(input logic [2:0] m);
    return ~m[`PMCS_MODE_SHUNT_BIT] & ~m[`PMCS_MODE_BUS_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-sample arithmetic, single cycle so no conversion time is added

  logic signed [32:0] cur_prod;
  logic [15:0] cur_sample;
  logic [31:0] cur_mag;
  logic [47:0] pow_prod;
  logic [15:0] pow_sample;

  // current from shunt sample and calibration
  always_comb begin
    cur_prod = $signed({{17{adc_data[15]}}, adc_data}) * $signed({17'h0_0000, st_reg.calib});
    cur_sample = st_reg.calib_valid ? cur_prod[`PMCS_CUR_SHIFT +: 16] : 16'h0000;
  end

  // power from last current and new bus sample
  always_comb begin
    cur_mag = {16'h0000, (st_reg.last_cur[15] ? 16'(-st_reg.last_cur) : st_reg.last_cur)};
    pow_prod = {16'h0000, cur_mag} * {32'h0000_0000, adc_data};
    pow_sample = st_reg.calib_valid ? pow_prod[`PMCS_POW_SHIFT +: 16] : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic [3:0] sh;
    logic [10:0] navg;
    logic sample_end;
    logic set_evt;
    logic clr_evt;
    logic bus_go;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    logic [2:0] new_mode;
    logic [31:0] cal_new;
    sh = avg_shift(st_reg.avg_sel);
    navg = 11'(11'h001 << sh);
    sample_end = 1'b0;
    set_evt = 1'b0;
    clr_evt = 1'b0;
    bus_go = (avs_read | avs_write) & ~st_reg.wait_req;
    cfg_word = 32'h0000_0000;
    cfg_word[`PMCS_MODE_MSB:`PMCS_MODE_LSB] = st_reg.mode;
    cfg_word[`PMCS_AVG_MSB:`PMCS_AVG_LSB] = st_reg.avg_sel;
    cfg_new = merge(cfg_word, avs_writedata, avs_byteenable);
    new_mode = cfg_new[`PMCS_MODE_MSB:`PMCS_MODE_LSB];
    // calibration merge kept whole; only its low half is stored
    cal_new = merge({16'h0000, st_reg.calib}, avs_writedata, avs_byteenable);
    st_next = st_reg;
    st_next.adc_start = 1'b0;

    // sequencer
    unique case (st_reg.state)
      S_IDLE: begin
        st_next.state = S_IDLE;
      end
      // count out the wake-up time before the first conversion
      S_RECOVER: begin
        if (st_reg.rec_cnt >= 12'(RECOVER_CYC - 1)) begin
          st_next.state = S_START;
          st_next.chan = first_chan(st_reg.mode);
          st_next.rec_cnt = 12'h000;
        end else begin
          st_next.rec_cnt = st_reg.rec_cnt + 12'h001;
        end
      end
      S_START: begin
        st_next.adc_start = 1'b1;
        st_next.state = S_WAIT;
      end
      S_WAIT: begin
        if (adc_done) begin
          if (st_reg.restart_pend) begin
            // stale result from an abandoned sample is dropped
            st_next.restart_pend = 1'b0;
            st_next.state = S_START;
            st_next.chan = first_chan(st_reg.mode);
          end else if (!st_reg.chan) begin
            // shunt sample and its current go to the sums
            st_next.acc_shunt = st_reg.acc_shunt + {{16{adc_data[15]}}, adc_data};
            st_next.acc_cur = st_reg.acc_cur + {{16{cur_sample[15]}}, cur_sample};
            st_next.last_cur = cur_sample;
            if (st_reg.mode[`PMCS_MODE_BUS_BIT]) begin
              st_next.chan = 1'b1;
              st_next.state = S_START;
            end else begin
              sample_end = 1'b1;
            end
          end else begin
            // bus sample, 1.25 mV per bit, and power to the sums
            st_next.acc_bus = st_reg.acc_bus + {16'h0000, adc_data};
            st_next.acc_pow = st_reg.acc_pow + {16'h0000, pow_sample};
            sample_end = 1'b1;
          end
        end
      end
    endcase

    // end of one sample: more samples, or load the averages
    if (sample_end) begin
      if (st_reg.samp_cnt + 11'h001 >= navg) begin
        if (st_reg.mode[`PMCS_MODE_SHUNT_BIT]) begin
          st_next.res_shunt = 16'($signed(st_next.acc_shunt) >>> sh);
          st_next.res_cur = 16'($signed(st_next.acc_cur) >>> sh);
        end
        if (st_reg.mode[`PMCS_MODE_BUS_BIT]) begin
          st_next.res_bus = 16'(st_next.acc_bus >> sh);
          st_next.res_pow = 16'(st_next.acc_pow >> sh);
        end
        st_next.acc_shunt = 32'h0000_0000;
        st_next.acc_bus = 32'h0000_0000;
        st_next.acc_cur = 32'h0000_0000;
        st_next.acc_pow = 32'h0000_0000;
        st_next.samp_cnt = 11'h000;
        set_evt = 1'b1;
        if (st_reg.mode[`PMCS_MODE_CONT_BIT]) begin
          st_next.state = S_START;
          st_next.chan = first_chan(st_reg.mode);
        end else begin
          st_next.state = S_IDLE;
        end
      end else begin
        st_next.samp_cnt = st_reg.samp_cnt + 11'h001;
        st_next.state = S_START;
        st_next.chan = first_chan(st_reg.mode);
      end
    end

    // bus handshake: answer one cycle after the request appears
    if ((avs_read | avs_write) && st_reg.wait_req) begin
      st_next.wait_req = 1'b0;
      st_next.rdata = 32'h0000_0000;
      // read data captured here; result reads touch nothing else
      unique case (avs_address)
        `PMCS_OFS_CONFIG: st_next.rdata = cfg_word;
        `PMCS_OFS_CALIB: st_next.rdata = {16'h0000, st_reg.calib};
        `PMCS_OFS_STATUS: begin
          st_next.rdata[`PMCS_ST_READY_BIT] = st_reg.ready_flag;
          st_next.rdata[`PMCS_ST_BUSY_BIT] = (st_reg.state != S_IDLE);
          st_next.rdata[`PMCS_ST_PD_BIT] = st_reg.power_down;
          st_next.rdata[`PMCS_ST_RECOVER_BIT] = (st_reg.state == S_RECOVER);
        end
        `PMCS_OFS_SHUNT: st_next.rdata = {16'h0000, st_reg.res_shunt};
        `PMCS_OFS_BUS: st_next.rdata = {16'h0000, st_reg.res_bus};
        `PMCS_OFS_CURRENT: st_next.rdata = {16'h0000, st_reg.res_cur};
        `PMCS_OFS_POWER: st_next.rdata = {16'h0000, st_reg.res_pow};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // request takes effect at the edge where waitrequest is low
    if (bus_go) begin
      st_next.wait_req = 1'b1;
      if (avs_read && avs_address == `PMCS_OFS_STATUS) begin
        clr_evt = 1'b1;
      end
      if (avs_write && avs_address == `PMCS_OFS_CALIB) begin
        st_next.calib = cal_new[15:0];
        st_next.calib_valid = 1'b1;
      end
      if (avs_write && avs_address == `PMCS_OFS_CONFIG) begin
        st_next.mode = new_mode;
        st_next.avg_sel = cfg_new[`PMCS_AVG_MSB:`PMCS_AVG_LSB];
        // every config write drops partial sums; only active modes restart
        st_next.acc_shunt = 32'h0000_0000;
        st_next.acc_bus = 32'h0000_0000;
        st_next.acc_cur = 32'h0000_0000;
        st_next.acc_pow = 32'h0000_0000;
        st_next.samp_cnt = 11'h000;
        st_next.restart_pend = 1'b0;
        if (is_pd(new_mode)) begin
          // power-down keeps the flag and stops sequencing
          st_next.power_down = 1'b1;
          st_next.state = S_IDLE;
          st_next.rec_cnt = 12'h000;
        end else begin
          clr_evt = 1'b1;
          st_next.chan = first_chan(new_mode);
          if (st_reg.power_down) begin
            st_next.power_down = 1'b0;
            st_next.state = S_RECOVER;
            st_next.rec_cnt = 12'h000;
          end else if (st_reg.state == S_RECOVER) begin
            st_next.state = S_RECOVER;
            st_next.rec_cnt = st_reg.rec_cnt;
          end else if (st_reg.state == S_WAIT && !adc_done) begin
            // conversion still in flight; its result is discarded
            st_next.state = S_WAIT;
            st_next.restart_pend = 1'b1;
          end else begin
            st_next.state = S_START;
          end
        end
      end
    end

    // flag: a set in the same cycle as a clear wins
    if (set_evt) begin
      st_next.ready_flag = 1'b1;
    end else if (clr_evt) begin
      st_next.ready_flag = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= S_RECOVER;
      st_reg.mode <= `PMCS_RST_MODE;
      st_reg.avg_sel <= `PMCS_RST_AVG;
      st_reg.calib <= `PMCS_RST_CALIB;
      st_reg.wait_req <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.wait_req;
  assign adc_start = st_reg.adc_start;
  assign adc_channel = st_reg.chan;
  assign adc_power_down = st_reg.power_down;
  assign conversion_ready_flag = st_reg.ready_flag;

endmodule

`default_nettype wire

// >>> test/pmcs_seq_checker.sv
`include "pmcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmcs_seq_checker #(
  parameter int RECOVER_CYC = 2000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // converter side
  input wire logic adc_start,
  input wire logic adc_channel,
  input wire logic adc_power_down,
  input wire logic adc_done,
  // status
  input wire logic conversion_ready_flag
);
  logic [15:0] up_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // cycles since converter power returned; saturates so it never wraps
  always_ff @(posedge core_clk) begin
    if (rst || adc_power_down) begin
      up_reg <= 16'h0000;
    end else if (up_reg != 16'hffff) begin
      up_reg <= up_reg + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////
  // answered accesses, the moment their side effects land
  sequence s_cfg_wr;
    avs_write && !avs_waitrequest && avs_address == `PMCS_OFS_CONFIG;
  endsequence
  sequence s_stat_rd;
    avs_read && !avs_waitrequest && avs_address == `PMCS_OFS_STATUS;
  endsequence
  property p_ans_next;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_ans_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_start_pulse;
    adc_start |=> !adc_start;
  endproperty
  property p_chan_hold;
    adc_start |=> $stable(adc_channel);
  endproperty
  property p_pd_quiet;
    adc_power_down |-> !adc_start;
  endproperty
  // two cycles slack: the first start comes when the counter reads RECOVER_CYC + 1
  property p_recover;
    adc_start |-> up_reg >= RECOVER_CYC - 1;
  endproperty
  property p_pd_enter;
    s_cfg_wr ##0 avs_writedata[1:0] == 2'b00 |=> adc_power_down;
  endproperty
  property p_pd_keep;
    s_cfg_wr ##0 (avs_writedata[1:0] == 2'b00 && conversion_ready_flag) |=> conversion_ready_flag;
  endproperty
  // a same-cycle set wins, so done cycles are excluded
  property p_cfg_clr;
    s_cfg_wr ##0 (avs_writedata[1:0] != 2'b00 && !adc_done) |=> !conversion_ready_flag;
  endproperty
  property p_stat_clr;
    s_stat_rd ##0 !adc_done |=> !conversion_ready_flag;
  endproperty
  property p_flag_hold;
    conversion_ready_flag && (avs_waitrequest || !(avs_write || avs_read &&
      avs_address == `PMCS_OFS_STATUS)) |=> conversion_ready_flag;
  endproperty
  property p_flag_src;
    $rose(conversion_ready_flag) |-> $past(adc_done);
  endproperty
  a_ans_next: assert property (p_ans_next) else $error("bus answer late");
  a_ans_once: assert property (p_ans_once) else $error("bus answer too long");
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  a_pd_quiet: assert property (p_pd_quiet) else $error("start in power-down");
  a_recover: assert property (p_recover) else $error("recovery too short");
  a_pd_enter: assert property (p_pd_enter) else $error("no power-down");
  a_pd_keep: assert property (p_pd_keep) else $error("flag lost on power-down");
  a_cfg_clr: assert property (p_cfg_clr) else $error("flag kept on config");
  a_stat_clr: assert property (p_stat_clr) else $error("flag kept on status");
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  a_flag_src: assert property (p_flag_src) else $error("flag without result");
endmodule
`default_nettype wire

// >>> test/pmcs_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmcs_adc_model #(
  parameter logic [15:0] SH_VAL = 16'h0100,
  parameter logic [15:0] BUS_VAL = 16'h0200
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // requests from the sequencer, and latency set by the bench
  input wire logic adc_start,
  input wire logic adc_channel,
  input wire logic adc_power_down,
  input wire logic [7:0] lat,
  // results
  output logic adc_done,
  output logic [15:0] adc_data = 16'h0000
);
  logic busy = 1'b0;
  logic ch = 1'b0;
  logic [7:0] cnt = 8'h00;
  ////////////////////////////////////////////////////////////////
  // data toggles outside done so stale values never look valid
  always @(posedge core_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (rst || adc_power_down) begin
      busy <= 1'b0;
    end else if (adc_start) begin
      busy <= 1'b1;
      cnt <= lat;
      ch <= adc_channel;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      adc_done <= 1'b1;
      adc_data <= ch ? BUS_VAL : SH_VAL; // bus code in 1.25 mV steps
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
`include "pmcs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmcs_pkg::*;
  localparam pmcs_word_t SH = 16'h0100;
  localparam pmcs_word_t BV = 16'h0200;
  localparam pmcs_word_t CAL = 16'h0800;
  localparam logic [31:0] ECUR = (32'(SH) * 32'(CAL)) >> `PMCS_CUR_SHIFT;
  localparam logic [31:0] EPOW = (ECUR * 32'(BV)) >> `PMCS_POW_SHIFT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, adc_start, adc_channel, adc_power_down, adc_done, conversion_ready_flag;
  pmcs_word_t adc_data;
  logic [7:0] lat = 8'h14;
  int err_count = 0, total_checks = 0, starts = 0, s0;
  int md[3] = '{1, 2, 3};
  int ns[3] = '{4, 4, 8};
  // 50 MHz clock and a start counter sampled like the design samples
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (adc_start === 1'b1) starts <= starts + 1;
  pmcs_top #(.RECOVER_CYC(4)) u_pmcs_top (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_power_down(adc_power_down), .adc_done(adc_done), .adc_data(adc_data),
    .conversion_ready_flag(conversion_ready_flag));
  pmcs_adc_model #(.SH_VAL(SH), .BUS_VAL(BV)) u_pmcs_adc_model (.core_clk(core_clk),
    .rst(rst), .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_power_down(adc_power_down), .lat(lat), .adc_done(adc_done), .adc_data(adc_data));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk);
    // no local limit: only the watchdog may end a hung access
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_flag();
    int n = 0;
    while (conversion_ready_flag !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("ready flag", 1, conversion_ready_flag);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wait_flag();
    acc(0, `PMCS_OFS_SHUNT, 0);
    chk("shunt", 32'(SH), rd);
    acc(0, `PMCS_OFS_BUS, 0);
    chk("bus", 32'(BV), rd);
    acc(0, `PMCS_OFS_CURRENT, 0);
    chk("current uncal", 0, rd);
    acc(0, `PMCS_OFS_POWER, 0);
    chk("power uncal", 0, rd);
    acc(0, `PMCS_OFS_STATUS, 0);
    chk("status ready", 1, rd[0]);
    chk("flag after status", 0, conversion_ready_flag);
    acc(1, `PMCS_OFS_CALIB, 32'(CAL));
    acc(1, `PMCS_OFS_CONFIG, 32'h0000_0003);
    s0 = starts;
    wait_flag();
    chk("single starts", 2, starts - s0);
    acc(0, `PMCS_OFS_CURRENT, 0);
    chk("current", ECUR, rd);
    acc(0, `PMCS_OFS_POWER, 0);
    chk("power", EPOW, rd);
    repeat (60) @(posedge core_clk);
    chk("stopped", 2, starts - s0);
    acc(0, `PMCS_OFS_SHUNT, 0);
    chk("shunt held", 32'(SH), rd);
    // four-sample sets in each triggered mode, prompt and slow converter
    for (int i = 0; i < 3; i++) begin
      lat <= (i == 0) ? 8'h01 : 8'h14;
      acc(1, `PMCS_OFS_CONFIG, {20'h0_0000, 3'h1, 6'h00, 3'(md[i])});
      s0 = starts;
      acc(0, `PMCS_OFS_SHUNT, 0);
      wait_flag();
      chk("set starts", ns[i], starts - s0);
      acc(0, `PMCS_OFS_CURRENT, 0);
      chk("avg current", ECUR, rd);
      acc(0, `PMCS_OFS_POWER, 0);
      chk("avg power", EPOW, rd);
    end
    acc(1, `PMCS_OFS_CONFIG, 0);
    chk("flag in power-down", 1, conversion_ready_flag);
    chk("power-down", 1, adc_power_down);
    acc(1, `PMCS_OFS_CALIB, 32'h0000_1000);
    acc(0, `PMCS_OFS_CALIB, 0);
    chk("calib", 32'h0000_1000, rd);
    s0 = starts;
    repeat (50) @(posedge core_clk);
    chk("pd starts", 0, starts - s0);
    acc(1, `PMCS_OFS_CONFIG, 32'h0000_0007);
    wait_flag();
    acc(0, `PMCS_OFS_CURRENT, 0);
    chk("new current", (32'(SH) * 32'h0000_1000) >> `PMCS_CUR_SHIFT, rd);
    acc(0, 5'h1c, 0);
    chk("unmapped", 0, rd);
    complete_run();
  end
endmodule
bind pmcs_top pmcs_seq_checker #(.RECOVER_CYC(RECOVER_CYC)) u_pmcs_seq_checker (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .adc_start(adc_start), .adc_channel(adc_channel), .adc_power_down(adc_power_down),
  .adc_done(adc_done), .conversion_ready_flag(conversion_ready_flag));
`default_nettype wire
